//--- logic/contact_input_consts.vh
// Constants for the contact input value sender: register map, field
// positions, reset values, value types and timebase figures.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
`ifndef CONTACT_INPUT_CONSTS_VH
`define CONTACT_INPUT_CONSTS_VH

// Register byte offsets
`define REG_CTRL 6'h00
`define REG_MIN_CLOSE 6'h04
`define REG_MIN_OPEN 6'h08
`define REG_RECOV_WAIT 6'h0c
`define REG_V0_CFG 6'h10
`define REG_V0_DATA 6'h14
`define REG_V1_CFG 6'h18
`define REG_V1_DATA 6'h1c
`define REG_BLOCK 6'h20
`define REG_STATUS 6'h24

// Control register fields
`define CTRL_SL_EN 0
`define CTRL_MIN_EN 1
`define CTRL_SCAN_EN 2
`define CTRL_CONTACT_OPEN 3
`define CTRL_DEB_LO 4
`define CTRL_DEB_HI 6
`define CTRL_LONG_LO 8
`define CTRL_LONG_HI 12
`define CTRL_RESET 32'h0000_0300

// Value config fields
`define VCFG_TYPE_LO 0
`define VCFG_TYPE_HI 3
`define VCFG_MODE_LO 4
`define VCFG_MODE_HI 5
`define VCFG_SAVE 6

// Reset values
`define MIN_RESET 16'h000a
`define RECOV_RESET 15'h0000

// Value types
`define VT_NONE 4'h0
`define VT_BIT1 4'h1
`define VT_FORCED 4'h2
`define VT_S8 4'h3
`define VT_U8 4'h4
`define VT_SCENE 4'h5
`define VT_S16 4'h6
`define VT_U16 4'h7
`define VT_F16 4'h8
`define VT_TIME 4'h9
`define VT_S32 4'ha
`define VT_U32 4'hb

// One-bit modes and forced-operation choices
`define MODE_OFF 2'h0
`define MODE_ON 2'h1
`define MODE_TOGGLE 2'h2
`define FORCE_CHOICE_OFF 2'h1
`define FORCE_CHOICE_ON 2'h2
`define FORCED_FREE 2'h0
`define FORCED_OFF 2'h2
`define FORCED_ON 2'h3

// Timebase and timing tables
`define CLK_PERIOD_NS 10
`define TIMEBASE_NS 1000000
`define TICK_DEFAULT 17'h1_86a0
`define MS_PER_DECI 24'h00_0064
`define MS_PER_SEC 10'h3e7
`define LONG_TABLE 136'h64_5a50_463c_3228_1e14_0f0c_0a08_0605_0403
`define LONG_ENTRIES 5'h10
`define DEB_TABLE 56'h96_6446_321e_140a
`define DEB_ENTRIES 3'h6

// Object numbering
`define OBJ_FIRST 8'h0a
`define OBJ_STRIDE 8'h0a
`define OBJ_VALUE1 8'h01
`define OBJ_VALUE2 8'h02

`endif

//--- logic/contact_input_value_sender.v
// Per-input event processor: debounces a contact, classifies short and long
// actuation or applies a minimum signal time, and emits typed telegrams.
// Assumes a 100 MHz sys_clk, a synchronous reset and a bus stack that takes
// telegrams with a valid/ready handshake; contact and manual pins are async.
`timescale 1ns/1ps
`default_nettype none
`include "contact_input_consts.vh"

module contact_input_value_sender #(
  parameter [2:0] INPUT_INDEX = 3'h0,
  parameter [16:0] TICK_CYCLES = `TICK_DEFAULT
) (
  input wire sys_clk,
  input wire srst,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire contact_in,
  input wire manual_active,
  input wire manual_state,
  input wire download_evt,
  input wire reset_evt,
  input wire bus_recover_evt,
  output reg tx_valid,
  input wire tx_ready,
  output reg [7:0] tx_object,
  output reg [3:0] tx_type,
  output reg [31:0] tx_data
);

  localparam [1:0] PH_IDLE = 2'h0;
  localparam [1:0] PH_PRESS = 2'h1;
  localparam [1:0] PH_HELD = 2'h2;
  localparam [1:0] PH_MINSIG = 2'h3;
  localparam [7:0] OBJ_BASE = `OBJ_FIRST + `OBJ_STRIDE * {5'h00, INPUT_INDEX};

  // Tenths of a second for a long-press index, clamped to the last entry
  function [7:0] long_tenths;
    input [4:0] idx;
    reg [4:0] i;
    reg [135:0] sh;
    begin
      i = (idx > `LONG_ENTRIES) ? `LONG_ENTRIES : idx;
      sh = `LONG_TABLE >> {i, 3'h0};
      long_tenths = sh[7:0];
    end
  endfunction

  // Debounce milliseconds for an index, clamped to the last entry
  function [7:0] deb_ms;
    input [2:0] idx;
    reg [2:0] i;
    reg [55:0] sh;
    begin
      i = (idx > `DEB_ENTRIES) ? `DEB_ENTRIES : idx;
      sh = `DEB_TABLE >> {i, 3'h0};
      deb_ms = sh[7:0];
    end
  endfunction

  // Builds the payload for one value; shared by both events
  function [31:0] encode;
    input [3:0] vtype;
    input [1:0] mode;
    input save;
    input [31:0] data;
    input last;
    reg [5:0] scene;
    begin
      scene = data[5:0] - 6'h01;
      case (vtype)
        `VT_BIT1: encode = {31'h0000_0000, (mode == `MODE_TOGGLE) ? ~last : (mode == `MODE_ON)};
        `VT_FORCED: begin
          case (data[1:0])
            `FORCE_CHOICE_OFF: encode = {30'h0000_0000, `FORCED_OFF};
            `FORCE_CHOICE_ON: encode = {30'h0000_0000, `FORCED_ON};
            default: encode = {30'h0000_0000, `FORCED_FREE};
          endcase
        end
        `VT_S8, `VT_U8: encode = {24'h00_0000, data[7:0]};
        `VT_SCENE: encode = {24'h00_0000, save, 1'b0, scene};
        `VT_S16, `VT_U16, `VT_F16: encode = {16'h0000, data[15:0]};
        `VT_TIME: encode = {8'h00, data[26:24], data[20:16], 2'h0, data[13:8], 2'h0, data[5:0]};
        `VT_S32, `VT_U32: encode = data;
        default: encode = 32'h0000_0000;
      endcase
    end
  endfunction

  // Configuration and object registers
  reg [31:0] ctrl;
  reg [15:0] min_close;
  reg [15:0] min_open;
  reg [14:0] recov_wait;
  reg [6:0] v0_cfg;
  reg [31:0] v0_data;
  reg [6:0] v1_cfg;
  reg [31:0] v1_data;
  reg blocked;

  // Synchronisers
  reg c_meta;
  reg c_sync;
  reg ma_meta;
  reg ma_sync;
  reg ms_meta;
  reg ms_sync;

  // Timebase
  reg [16:0] tick_cnt;
  reg ms_tick;
  reg [9:0] sec_cnt;
  reg sec_tick;

  // Event processing state
  reg accepted;
  reg [7:0] deb_cnt;
  reg [1:0] phase;
  reg [23:0] timer;
  reg pend_close;
  reg block_prev;
  reg rec_busy;
  reg [14:0] rec_cnt;
  reg req_valid;
  reg req_sel;
  reg req_save;
  reg [1:0] last_bit;

  wire sl_en = ctrl[`CTRL_SL_EN];
  wire min_en = ctrl[`CTRL_MIN_EN];
  wire scan_en = ctrl[`CTRL_SCAN_EN];
  wire contact_open = ctrl[`CTRL_CONTACT_OPEN];

  // Manual operation overrides the pin and its edges are never held off by the block
  wire eff_state = ma_sync ? ms_sync : c_sync;
  wire can_sample = (deb_cnt == 8'h00) && (!blocked || ma_sync);
  wire edge_seen = can_sample && (eff_state != accepted);
  wire rec_fire = rec_busy && (rec_cnt == 15'h0000);
  wire rec_start = bus_recover_evt && scan_en;
  wire scan_fire = scan_en && (download_evt || reset_evt || rec_fire);
  wire fire = edge_seen || scan_fire;
  wire actuated_new = eff_state ^ contact_open;
  wire timing = (phase == PH_PRESS) || (phase == PH_MINSIG);
  wire pend_sel = (phase == PH_MINSIG) ? pend_close : 1'b0;
  wire [3:0] pend_type = pend_sel ? v1_cfg[`VCFG_TYPE_HI:`VCFG_TYPE_LO] : v0_cfg[`VCFG_TYPE_HI:`VCFG_TYPE_LO];
  wire [23:0] long_ms = {16'h0000, long_tenths(ctrl[`CTRL_LONG_HI:`CTRL_LONG_LO])} * `MS_PER_DECI;
  wire [39:0] min_prod = {24'h00_0000, eff_state ? min_close : min_open} * {16'h0000, `MS_PER_DECI};
  wire [23:0] min_ms = min_prod[23:0];

  // Two flip-flops on every asynchronous input before anything reads it
  always @(posedge sys_clk) begin
    if (srst) begin
      c_meta <= 1'b0;
      c_sync <= 1'b0;
      ma_meta <= 1'b0;
      ma_sync <= 1'b0;
      ms_meta <= 1'b0;
      ms_sync <= 1'b0;
    end else begin
      c_meta <= contact_in;
      c_sync <= c_meta;
      ma_meta <= manual_active;
      ma_sync <= ma_meta;
      ms_meta <= manual_state;
      ms_sync <= ms_meta;
    end
  end

  // Millisecond and second ticks shared by every timer
  always @(posedge sys_clk) begin
    if (srst) begin
      tick_cnt <= 17'h0_0000;
      ms_tick <= 1'b0;
      sec_cnt <= 10'h000;
      sec_tick <= 1'b0;
    end else begin
      ms_tick <= (tick_cnt == TICK_CYCLES - 17'h0_0001);
      sec_tick <= ms_tick && (sec_cnt == `MS_PER_SEC) && !rec_start;
      if (tick_cnt == TICK_CYCLES - 17'h0_0001) begin
        tick_cnt <= 17'h0_0000;
      end else begin
        tick_cnt <= tick_cnt + 17'h0_0001;
      end
      // Restart the second count so the recovery wait is whole seconds, not a part
      if (rec_start) begin
        sec_cnt <= 10'h000;
      end else if (ms_tick) begin
        sec_cnt <= (sec_cnt == `MS_PER_SEC) ? 10'h000 : sec_cnt + 10'h001;
      end
    end
  end

  // Wait after bus recovery before the input is rescanned
  always @(posedge sys_clk) begin
    if (srst) begin
      rec_busy <= 1'b0;
      rec_cnt <= 15'h0000;
    end else if (rec_start) begin
      rec_busy <= 1'b1;
      rec_cnt <= recov_wait;
    end else if (rec_fire) begin
      rec_busy <= 1'b0;
    end else if (rec_busy && sec_tick) begin
      rec_cnt <= rec_cnt - 15'h0001;
    end
  end

  // Edge handling, short/long timing and minimum signal time
  always @(posedge sys_clk) begin
    if (srst) begin
      accepted <= 1'b0;
      deb_cnt <= 8'h00;
      phase <= PH_IDLE;
      timer <= 24'h00_0000;
      pend_close <= 1'b0;
      block_prev <= 1'b0;
      req_valid <= 1'b0;
      req_sel <= 1'b0;
      req_save <= 1'b0;
    end else begin
      block_prev <= blocked;
      req_valid <= 1'b0;
      req_save <= 1'b0;
      if (ms_tick && deb_cnt != 8'h00) begin
        deb_cnt <= deb_cnt - 8'h01;
      end
      if (fire) begin
        accepted <= eff_state;
        if (edge_seen) begin
          deb_cnt <= deb_ms(ctrl[`CTRL_DEB_HI:`CTRL_DEB_LO]);
        end
        if (sl_en) begin
          if (actuated_new) begin
            phase <= PH_PRESS;
            timer <= long_ms;
          end else begin
            if (phase == PH_PRESS) begin
              req_valid <= 1'b1;
              req_sel <= 1'b0;
            end
            phase <= PH_IDLE;
          end
        end else if (min_en) begin
          phase <= PH_MINSIG;
          timer <= min_ms;
          pend_close <= eff_state;
        end else begin
          req_valid <= 1'b1;
          req_sel <= eff_state;
          phase <= PH_IDLE;
        end
      end else if (blocked && !block_prev && timing && pend_type == `VT_SCENE) begin
        // A scene action cut short by the block still has to end in a save
        req_valid <= 1'b1;
        req_sel <= pend_sel;
        req_save <= 1'b1;
        phase <= PH_IDLE;
      end else if (timing && !blocked) begin
        if (timer == 24'h00_0000) begin
          req_valid <= 1'b1;
          if (phase == PH_PRESS) begin
            req_sel <= 1'b1;
            phase <= PH_HELD;
          end else begin
            req_sel <= pend_close;
            phase <= PH_IDLE;
          end
        end else if (ms_tick) begin
          timer <= timer - 24'h00_0001;
        end
      end
    end
  end

  // Telegram stage; a newer telegram replaces one not yet taken
  always @(posedge sys_clk) begin
    if (srst) begin
      tx_valid <= 1'b0;
      tx_object <= 8'h00;
      tx_type <= `VT_NONE;
      tx_data <= 32'h0000_0000;
      last_bit <= 2'h0;
    end else if (req_valid) begin
      if (req_sel) begin
        tx_valid <= (v1_cfg[`VCFG_TYPE_HI:`VCFG_TYPE_LO] != `VT_NONE);
        tx_object <= OBJ_BASE + `OBJ_VALUE2;
        tx_type <= v1_cfg[`VCFG_TYPE_HI:`VCFG_TYPE_LO];
        tx_data <= encode(v1_cfg[`VCFG_TYPE_HI:`VCFG_TYPE_LO], v1_cfg[`VCFG_MODE_HI:`VCFG_MODE_LO],
                          v1_cfg[`VCFG_SAVE] | req_save, v1_data, last_bit[1]);
        if (v1_cfg[`VCFG_TYPE_HI:`VCFG_TYPE_LO] == `VT_BIT1) begin
          last_bit[1] <= (v1_cfg[`VCFG_MODE_HI:`VCFG_MODE_LO] == `MODE_TOGGLE) ? ~last_bit[1] :
                         (v1_cfg[`VCFG_MODE_HI:`VCFG_MODE_LO] == `MODE_ON);
        end
      end else begin
        tx_valid <= (v0_cfg[`VCFG_TYPE_HI:`VCFG_TYPE_LO] != `VT_NONE);
        tx_object <= OBJ_BASE + `OBJ_VALUE1;
        tx_type <= v0_cfg[`VCFG_TYPE_HI:`VCFG_TYPE_LO];
        tx_data <= encode(v0_cfg[`VCFG_TYPE_HI:`VCFG_TYPE_LO], v0_cfg[`VCFG_MODE_HI:`VCFG_MODE_LO],
                          v0_cfg[`VCFG_SAVE] | req_save, v0_data, last_bit[0]);
        if (v0_cfg[`VCFG_TYPE_HI:`VCFG_TYPE_LO] == `VT_BIT1) begin
          last_bit[0] <= (v0_cfg[`VCFG_MODE_HI:`VCFG_MODE_LO] == `MODE_TOGGLE) ? ~last_bit[0] :
                         (v0_cfg[`VCFG_MODE_HI:`VCFG_MODE_LO] == `MODE_ON);
        end
      end
    end else if (tx_valid && tx_ready) begin
      tx_valid <= 1'b0;
    end
  end

  // Avalon-MM slave: one wait cycle, then a single-cycle answer
  always @(posedge sys_clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      ctrl <= `CTRL_RESET;
      min_close <= `MIN_RESET;
      min_open <= `MIN_RESET;
      recov_wait <= `RECOV_RESET;
      v0_cfg <= 7'h00;
      v0_data <= 32'h0000_0000;
      v1_cfg <= 7'h00;
      v1_data <= 32'h0000_0000;
      blocked <= 1'b0;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      if (avs_write) begin
        case (avs_address)
          `REG_CTRL: ctrl <= avs_writedata;
          `REG_MIN_CLOSE: min_close <= avs_writedata[15:0];
          `REG_MIN_OPEN: min_open <= avs_writedata[15:0];
          `REG_RECOV_WAIT: recov_wait <= avs_writedata[14:0];
          `REG_V0_CFG: v0_cfg <= avs_writedata[6:0];
          `REG_V0_DATA: v0_data <= avs_writedata;
          `REG_V1_CFG: v1_cfg <= avs_writedata[6:0];
          `REG_V1_DATA: v1_data <= avs_writedata;
          `REG_BLOCK: blocked <= avs_writedata[0];
          default: blocked <= blocked;
        endcase
      end else begin
        case (avs_address)
          `REG_CTRL: avs_readdata <= ctrl;
          `REG_MIN_CLOSE: avs_readdata <= {16'h0000, min_close};
          `REG_MIN_OPEN: avs_readdata <= {16'h0000, min_open};
          `REG_RECOV_WAIT: avs_readdata <= {17'h0_0000, recov_wait};
          `REG_V0_CFG: avs_readdata <= {25'h000_0000, v0_cfg};
          `REG_V0_DATA: avs_readdata <= v0_data;
          `REG_V1_CFG: avs_readdata <= {25'h000_0000, v1_cfg};
          `REG_V1_DATA: avs_readdata <= v1_data;
          `REG_BLOCK: avs_readdata <= {31'h0000_0000, blocked};
          `REG_STATUS: avs_readdata <= {22'h00_0000, last_bit, tx_valid, rec_busy, phase,
                                        blocked, accepted ^ contact_open, accepted, c_sync};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

endmodule
`default_nettype wire

//--- bench/tele_sink.sv
// Bus stack stand-in that accepts telegrams from the sender.
// Assumes the bench raises stall to hold ready low for a while.
`timescale 1ns/1ps
`default_nettype none
module tele_sink (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic stall,
  output logic tx_ready
);
  // Ready follows stall one cycle late, so a pending telegram must stand
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= !stall;
    end
  end
endmodule
`default_nettype wire

//--- bench/contact_input_monitor.sv
// Checker for the sender: register handshake and telegram form.
// Sees only the sender's ports; bound onto every instance below.
`timescale 1ns/1ps
`default_nettype none
`include "contact_input_consts.vh"
module contact_input_monitor #(
  parameter [2:0] INPUT_INDEX = 3'h0
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_object,
  input wire logic [3:0] tx_type,
  input wire logic [31:0] tx_data
);
  localparam logic [7:0] BASE = `OBJ_FIRST + `OBJ_STRIDE * INPUT_INDEX;
  // One clock domain, so clock and reset are given once
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer held too long");
  a_answer_asked: assert property ($fell(avs_waitrequest) |-> $past(avs_read) || $past(avs_write))
    else $error("bus answer without request");
  a_tx_held: assert property (tx_valid && !tx_ready |=> tx_valid)
    else $error("telegram dropped before acceptance");
  a_obj_number: assert property (tx_valid |-> tx_object == BASE + `OBJ_VALUE1 || tx_object == BASE + `OBJ_VALUE2)
    else $error("telegram object number wrong");
  a_type_sent: assert property (tx_valid |-> tx_type != `VT_NONE && tx_type <= `VT_U32)
    else $error("telegram type invalid");
  a_forced_code: assert property (tx_valid && tx_type == `VT_FORCED |-> tx_data[1:0] != 2'h1 && tx_data[31:2] == 0)
    else $error("forced value badly coded");
  a_scene_form: assert property (tx_valid && tx_type == `VT_SCENE |-> tx_data[31:8] == 0 && !tx_data[6])
    else $error("scene value badly formed");
  a_time_range: assert property (tx_valid && tx_type == `VT_TIME |->
    tx_data[31:24] == 0 && tx_data[20:16] < 24 && tx_data[13:8] < 60 && tx_data[5:0] < 60)
    else $error("time of day out of range");
  a_bit_value: assert property (tx_valid && tx_type == `VT_BIT1 |-> tx_data[31:1] == 0)
    else $error("one-bit value wider than a bit");
endmodule
bind contact_input_value_sender contact_input_monitor #(.INPUT_INDEX(INPUT_INDEX)) mon (.sys_clk, .srst,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .tx_valid,
  .tx_ready, .tx_object, .tx_type, .tx_data);
`default_nettype wire

//--- bench/contact_input_value_sender_tb.sv
// Self-checking bench for the contact input value sender.
// Assumes a tick of 10 cycles, so 100 ms lasts 1000 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "contact_input_consts.vh"
module contact_input_value_sender_tb;
  logic sys_clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, contact_in = 1'b0;
  logic manual_active = 1'b0, manual_state = 1'b0, download_evt = 1'b0, reset_evt = 1'b0;
  logic bus_recover_evt = 1'b0, stall = 1'b0, last0 = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0000_0000, c0, d0, x0, c1, d1, x1, e;
  logic [75:0] te;
  wire logic [31:0] avs_readdata, tx_data;
  wire logic avs_waitrequest, tx_valid, tx_ready;
  wire logic [7:0] tx_object;
  wire logic [3:0] tx_type;
  int n_errors = 0, n_compared = 0, cyc = 0;
  logic [75:0] tq[$];
  logic [31:0] rq[$];
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  contact_input_value_sender #(.TICK_CYCLES(17'h0_000a)) uut (.sys_clk, .srst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .contact_in, .manual_active, .manual_state,
    .download_evt, .reset_evt, .bus_recover_evt, .tx_valid, .tx_ready, .tx_object, .tx_type, .tx_data);
  tele_sink sink (.sys_clk, .srst, .stall, .tx_ready);
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  // Oldest note is matched against each read answer and each accepted telegram
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      e = rq.pop_front();
      chk(avs_readdata === e, "read data");
    end
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      te = (tq.size() > 0) ? tq.pop_front() : '1;
      chk(te[75:44] <= cyc && {tx_object, tx_type, tx_data} === te[43:0], "telegram early or wrong");
    end
  end
  task automatic tally_and_finish();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic stop_hang(input string m);
    n_errors++;
    $display("ERROR %0t timeout %s", $time, m);
    tally_and_finish();
  endtask
  // Request held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 50);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i >= 50) stop_hang("bus");
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] x);
    rq.push_back(x);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic tel(input int dly, input logic [7:0] o, input logic [3:0] t, input logic [31:0] d);
    tq.push_back({cyc + dly, o, t, d});
  endtask
  // Waits for all noted telegrams, then idles past the debounce window
  task automatic drain(input int n);
    int i;
    for (i = 0; i < n && tq.size() > 0; i++) @(posedge sys_clk);
    if (tq.size() > 0) stop_hang("telegram");
    repeat (150) @(posedge sys_clk);
  endtask
  task automatic pin(input logic v);
    @(posedge sys_clk);
    contact_in <= v;
  endtask
  task automatic evt(input logic [2:0] w);
    @(posedge sys_clk);
    {bus_recover_evt, reset_evt, download_evt} <= w;
    @(posedge sys_clk);
    {bus_recover_evt, reset_evt, download_evt} <= 3'h0;
  endtask
  // Random in-range value of type k, with the payload the wire must show
  task automatic mk(input int k, input logic ev, output logic [31:0] c, output logic [31:0] d,
    output logic [31:0] x);
    logic [31:0] r;
    logic [3:0] t;
    r = $urandom;
    t = (k == 12) ? `VT_BIT1 : k[3:0];
    c = {28'h000_0000, t};
    d = r;
    case (t)
      `VT_BIT1: c[5:4] = ev ? ((k == 1) ? `MODE_ON : `MODE_OFF) : `MODE_TOGGLE;
      `VT_FORCED: d = r % 3;
      `VT_S8: d = r & 32'h0000_007f;
      `VT_U8: d = r & 32'h0000_00ff;
      `VT_SCENE: begin
        c[6] = r[9];
        d = 1 + r[5:0] % 63;
      end
      `VT_S16: d = r & 32'h0000_7fff;
      `VT_U16, `VT_F16: d = r & 32'h0000_ffff;
      `VT_TIME: d = {5'h00, r[26:24], 3'h0, 5'(r[20:16] % 24), 2'h0, 6'(r[15:8] % 60), 2'h0, 6'(r[7:0] % 60)};
      `VT_S32: d = r & 32'h7fff_ffff;
      default: ;
    endcase
    x = d;
    if (t == `VT_FORCED) x = (d == 0) ? 0 : d + 1;
    if (t == `VT_SCENE) x = {24'h00_0000, c[6], 1'b0, 6'(d - 1)};
    if (t == `VT_TIME) x = {8'h00, d[26:24], d[20:16], 2'h0, d[13:8], 2'h0, d[5:0]};
    if (t == `VT_BIT1) begin
      if (!ev) last0 = !last0;
      x = ev ? (k == 1) : last0;
    end
  endtask
  initial begin
    int k;
    void'($urandom(32'h656f));
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    rd(`REG_CTRL, `CTRL_RESET);
    rd(`REG_MIN_CLOSE, 32'h0000_000a);
    rd(`REG_MIN_OPEN, 32'h0000_000a);
    rd(`REG_RECOV_WAIT, 32'h0000_0000);
    wr(6'h2c, $urandom);
    rd(6'h2c, 32'h0000_0000);
    wr(`REG_BLOCK, 32'h0000_0001);
    rd(`REG_BLOCK, 32'h0000_0001);
    wr(`REG_BLOCK, 32'h0000_0000);
    $display("test registers finished");
    // Every type on both events; the last pass repeats one-bit with off in place of on for value 2
    for (k = 0; k < 13; k++) begin
      mk(k, 1'b0, c0, d0, x0);
      mk(k, 1'b1, c1, d1, x1);
      wr(`REG_V0_CFG, c0);
      wr(`REG_V0_DATA, d0);
      wr(`REG_V1_CFG, c1);
      wr(`REG_V1_DATA, d1);
      stall <= k[0];
      pin(1'b1);
      if (k != 0) tel(1, 8'h0c, c1[3:0], x1);
      repeat (40) @(posedge sys_clk);
      stall <= 1'b0;
      drain(300);
      pin(1'b0);
      if (k != 0) tel(1, 8'h0b, c0[3:0], x0);
      drain(300);
    end
    $display("test value types finished");
    wr(`REG_V0_CFG, 32'h0000_0004);
    wr(`REG_V0_DATA, 32'h0000_0011);
    wr(`REG_V1_CFG, 32'h0000_0004);
    wr(`REG_V1_DATA, 32'h0000_0022);
    wr(`REG_CTRL, 32'h0000_0001);
    pin(1'b1);
    repeat (500) @(posedge sys_clk);
    pin(1'b0);
    tel(1, 8'h0b, 4'h4, 32'h0000_0011);
    drain(50);
    pin(1'b1);
    tel(2990, 8'h0c, 4'h4, 32'h0000_0022);
    drain(3300);
    pin(1'b0);
    repeat (300) @(posedge sys_clk);
    wr(`REG_CTRL, 32'h0000_0000);
    pin(1'b1);
    tel(1, 8'h0c, 4'h4, 32'h0000_0022);
    drain(50);
    wr(`REG_CTRL, 32'h0000_0009);
    pin(1'b0);
    repeat (500) @(posedge sys_clk);
    pin(1'b1);
    tel(1, 8'h0b, 4'h4, 32'h0000_0011);
    drain(50);
    $display("test short long finished");
    wr(`REG_MIN_CLOSE, 32'h0000_0002);
    wr(`REG_MIN_OPEN, 32'h0000_0001);
    wr(`REG_CTRL, 32'h0000_0002);
    pin(1'b0);
    repeat (500) @(posedge sys_clk);
    pin(1'b1);
    tel(1990, 8'h0c, 4'h4, 32'h0000_0022);
    drain(2200);
    pin(1'b0);
    tel(990, 8'h0b, 4'h4, 32'h0000_0011);
    drain(1200);
    // Block while a scene waits out its minimum time: the scene goes out saved
    wr(`REG_V1_CFG, 32'h0000_0005);
    wr(`REG_V1_DATA, 32'h0000_0003);
    pin(1'b1);
    repeat (200) @(posedge sys_clk);
    tel(0, 8'h0c, 4'h5, 32'h0000_0082);
    wr(`REG_BLOCK, 32'h0000_0001);
    drain(50);
    wr(`REG_BLOCK, 32'h0000_0000);
    wr(`REG_V1_CFG, 32'h0000_0004);
    wr(`REG_V1_DATA, 32'h0000_0022);
    pin(1'b0);
    tel(990, 8'h0b, 4'h4, 32'h0000_0011);
    drain(1200);
    $display("test minimum signal finished");
    wr(`REG_CTRL, 32'h0000_0000);
    wr(`REG_BLOCK, 32'h0000_0001);
    pin(1'b1);
    repeat (300) @(posedge sys_clk);
    tel(0, 8'h0c, 4'h4, 32'h0000_0022);
    wr(`REG_BLOCK, 32'h0000_0000);
    drain(20);
    wr(`REG_BLOCK, 32'h0000_0001);
    @(posedge sys_clk);
    manual_state <= 1'b1;
    manual_active <= 1'b1;
    repeat (200) @(posedge sys_clk);
    manual_state <= 1'b0;
    tel(1, 8'h0b, 4'h4, 32'h0000_0011);
    drain(50);
    manual_state <= 1'b1;
    tel(1, 8'h0c, 4'h4, 32'h0000_0022);
    drain(50);
    manual_active <= 1'b0;
    wr(`REG_BLOCK, 32'h0000_0000);
    repeat (200) @(posedge sys_clk);
    $display("test block finished");
    wr(`REG_RECOV_WAIT, 32'h0000_0001);
    evt(3'h1);
    repeat (200) @(posedge sys_clk);
    wr(`REG_CTRL, 32'h0000_0004);
    tel(1, 8'h0c, 4'h4, 32'h0000_0022);
    evt(3'h1);
    drain(50);
    tel(1, 8'h0c, 4'h4, 32'h0000_0022);
    evt(3'h2);
    drain(50);
    tel(9990, 8'h0c, 4'h4, 32'h0000_0022);
    evt(3'h4);
    drain(10300);
    $display("test rescan finished");
    tally_and_finish();
  end
endmodule
`default_nettype wire
